// File: verilog/gpcm_top.sv
// What this block does
// - Direction bit one selects input, zero output
// - Polarity bit one inverts pin sense
// - Bit seven selects open drain, else push-pull
// - Function field bits 3:2; bits 6:4 unused
// - Lock pin code 11: either-edge interrupt three
// - Lock pin code 10: floppy indicator, edge interrupt
// - Lock code 01 forces non-inverted input
// - Lock code 01 ignores writes to field
// - Power-on and hard resets clear lock field
// - Locked, pin high: disable register read-only
// - Locked, pin low: disable register writable
// - Code 00 gives plain GPIO behaviour
// - Port5 pin0: 10 irq3, 01 ring indicator
// - Port5 pin1: 10 irq4, 01 carrier detect
`timescale 1ns/1ps
`include "gpcm_regs.svh"

module gpcm_top (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic trickle_supply_power_on_reset,
    input wire logic main_supply_power_on_reset,
    input wire logic hard_reset,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] pad_in,
    output logic [2:0] pad_out,
    output logic [2:0] pad_oe_n,
    input wire logic floppy_on_parallel_indicator,
    output logic irq3,
    output logic irq4,
    output logic serial2_ring_indicator,
    output logic serial2_carrier_detect,
    output logic [7:0] device_disable,
    output logic disable_register_lock_function,
    output logic irq
);
    localparam gpcm_pkg::gpcm_state_t S_RST = '{
        cfg: {3{`GPCM_CFG_RST}},
        default: '0
    };

    gpcm_pkg::gpcm_state_t s_r;
    gpcm_pkg::gpcm_state_t s_nxt;

    logic [2:0] pin_sense;
    logic [1:0] func43;
    logic [1:0] func50;
    logic [1:0] func51;
    logic lock_sel;
    logic lock_ro;
    logic wr_go;
    logic wr_lo;
    logic [1:0] ev;
    logic [1:0] clr;

    assign func43 = s_r.cfg[0][`GPCM_FUNC_MSB:`GPCM_FUNC_LSB];
    assign func50 = s_r.cfg[1][`GPCM_FUNC_MSB:`GPCM_FUNC_LSB];
    assign func51 = s_r.cfg[2][`GPCM_FUNC_MSB:`GPCM_FUNC_LSB];
    assign lock_sel = (func43 == `GPCM_FUNC_ALT1);
    assign lock_ro = lock_sel & pad_in[0];
    assign wr_go = s_r.aw_v & s_r.w_v & ~s_r.b_v;
    assign wr_lo = wr_go & s_r.w_strb[0];

    // Lock pin: floppy indicator drives it under code 10 when the direction bit selects output
    gpcm_pin u_pin43 (
        .cfg(s_r.cfg[0]),
        .force_in(lock_sel),
        .gpio_out(s_r.gpio_out[0]),
        .alt_drive(func43 == `GPCM_FUNC_ALT2),
        .alt_value(floppy_on_parallel_indicator),
        .pad_in(pad_in[0]),
        .pad_out(pad_out[0]),
        .pad_oe_n(pad_oe_n[0]),
        .pin_sense(pin_sense[0])
    );

    // Port5 alternates are all inputs; the pin follows its direction bit
    gpcm_pin u_pin50 (
        .cfg(s_r.cfg[1]),
        .force_in(1'b0),
        .gpio_out(s_r.gpio_out[1]),
        .alt_drive(1'b0),
        .alt_value(1'b0),
        .pad_in(pad_in[1]),
        .pad_out(pad_out[1]),
        .pad_oe_n(pad_oe_n[1]),
        .pin_sense(pin_sense[1])
    );

    gpcm_pin u_pin51 (
        .cfg(s_r.cfg[2]),
        .force_in(1'b0),
        .gpio_out(s_r.gpio_out[2]),
        .alt_drive(1'b0),
        .alt_value(1'b0),
        .pad_in(pad_in[2]),
        .pad_out(pad_out[2]),
        .pad_oe_n(pad_oe_n[2]),
        .pin_sense(pin_sense[2])
    );

    // Code 11 on port5 pins falls back to plain GPIO routing
    assign irq3 = (func50 == `GPCM_FUNC_ALT2) & pin_sense[1];
    assign irq4 = (func51 == `GPCM_FUNC_ALT2) & pin_sense[2];
    assign serial2_ring_indicator =
        (func50 == `GPCM_FUNC_ALT1) ? pin_sense[1] : 1'b1;
    assign serial2_carrier_detect =
        (func51 == `GPCM_FUNC_ALT1) ? pin_sense[2] : 1'b1;
    assign device_disable = s_r.dev_dis;
    assign disable_register_lock_function = lock_sel;
    assign irq = |(s_r.int_sts & s_r.int_en);

    assign ev[`GPCM_EV_EDGE3] = (func43 == `GPCM_FUNC_ALT3)
        & (pad_in[0] != s_r.pin_prev[0]);
    assign ev[`GPCM_EV_FLOPPY] = (func43 == `GPCM_FUNC_ALT2)
        & (pad_in[0] != s_r.pin_prev[0]);
    assign clr = (wr_lo && s_r.aw_addr == `GPCM_ADDR_INT_CLR)
        ? s_r.w_data[1:0] : 2'h0;

    assign s_axi_awready = ~s_r.aw_v;
    assign s_axi_wready = ~s_r.w_v;
    assign s_axi_bvalid = s_r.b_v;
    assign s_axi_bresp = s_r.b_resp;
    assign s_axi_arready = ~s_r.r_v;
    assign s_axi_rvalid = s_r.r_v;
    assign s_axi_rdata = s_r.r_data;
    assign s_axi_rresp = s_r.r_resp;

    always_comb begin
        s_nxt = s_r;
        s_nxt.pin_prev = pad_in;
        // Set beats clear when both land in one cycle
        s_nxt.int_sts = (s_r.int_sts & ~clr) | ev;

        if (s_axi_awvalid && !s_r.aw_v) begin
            s_nxt.aw_v = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_v) begin
            s_nxt.w_v = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        if (s_r.b_v && s_axi_bready) begin
            s_nxt.b_v = 1'b0;
        end

        if (wr_go) begin
            s_nxt.aw_v = 1'b0;
            s_nxt.w_v = 1'b0;
            s_nxt.b_v = 1'b1;
            s_nxt.b_resp = `GPCM_RESP_OKAY;
            unique case (s_r.aw_addr)
                `GPCM_ADDR_CFG43: begin
                    if (wr_lo) begin
                        s_nxt.cfg[0] = s_r.w_data[7:0];
                        if (lock_sel) begin
                            // Locked field survives every write
                            s_nxt.cfg[0][`GPCM_FUNC_MSB:`GPCM_FUNC_LSB] =
                                `GPCM_FUNC_ALT1;
                        end
                    end
                end
                `GPCM_ADDR_CFG50: begin
                    if (wr_lo) begin
                        s_nxt.cfg[1] = s_r.w_data[7:0];
                    end
                end
                `GPCM_ADDR_CFG51: begin
                    if (wr_lo) begin
                        s_nxt.cfg[2] = s_r.w_data[7:0];
                    end
                end
                `GPCM_ADDR_DATA: begin
                    if (wr_lo) begin
                        s_nxt.gpio_out = s_r.w_data[2:0];
                    end
                end
                `GPCM_ADDR_INT_STS, `GPCM_ADDR_INT_CLR: begin
                end
                `GPCM_ADDR_INT_EN: begin
                    if (wr_lo) begin
                        s_nxt.int_en = s_r.w_data[1:0];
                    end
                end
                `GPCM_ADDR_DEV_DIS: begin
                    if (wr_lo && !lock_ro) begin
                        s_nxt.dev_dis = s_r.w_data[7:0];
                    end
                end
                default: begin
                    s_nxt.b_resp = `GPCM_RESP_SLVERR;
                end
            endcase
        end

        if (s_r.r_v && s_axi_rready) begin
            s_nxt.r_v = 1'b0;
        end
        if (s_axi_arvalid && !s_r.r_v) begin
            s_nxt.r_v = 1'b1;
            s_nxt.r_data = 32'h0000_0000;
            s_nxt.r_resp = `GPCM_RESP_OKAY;
            unique case (s_axi_araddr)
                `GPCM_ADDR_CFG43: s_nxt.r_data[7:0] = s_r.cfg[0];
                `GPCM_ADDR_CFG50: s_nxt.r_data[7:0] = s_r.cfg[1];
                `GPCM_ADDR_CFG51: s_nxt.r_data[7:0] = s_r.cfg[2];
                `GPCM_ADDR_DATA: begin
                    s_nxt.r_data[2:0] = s_r.gpio_out;
                    s_nxt.r_data[`GPCM_DATA_IN_LSB +: 3] = pin_sense;
                end
                `GPCM_ADDR_INT_STS: s_nxt.r_data[1:0] = s_r.int_sts;
                `GPCM_ADDR_INT_CLR: begin
                end
                `GPCM_ADDR_INT_EN: s_nxt.r_data[1:0] = s_r.int_en;
                `GPCM_ADDR_DEV_DIS: s_nxt.r_data[7:0] = s_r.dev_dis;
                default: s_nxt.r_resp = `GPCM_RESP_SLVERR;
            endcase
        end

        // Trickle reset outranks any cfg write in the same cycle; main and hard resets only the lock field
        if (trickle_supply_power_on_reset) begin
            s_nxt.cfg = {3{`GPCM_CFG_RST}};
        end
        if (main_supply_power_on_reset || hard_reset
                || trickle_supply_power_on_reset) begin
            s_nxt.cfg[0][`GPCM_FUNC_MSB:`GPCM_FUNC_LSB] =
                `GPCM_FUNC_GPIO;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_r <= S_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_dir_input;
        s_r.cfg[1][`GPCM_BIT_DIR] |-> pad_oe_n[1];
    endproperty
    a_dir_input: assert property (p_dir_input)
        else $error("input pin is driven");

    property p_pol_ring;
        func50 == `GPCM_FUNC_ALT1 |->
            serial2_ring_indicator == (pad_in[1] ^ s_r.cfg[1][1]);
    endproperty
    a_pol_ring: assert property (p_pol_ring)
        else $error("ring indicator sense wrong");

    property p_od_low;
        s_r.cfg[2][`GPCM_BIT_OD] && !pad_oe_n[2] |-> pad_out[2] == 1'b0;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open drain drove high");

    property p_edge3;
        func43 == `GPCM_FUNC_ALT3 && pad_in[0] != $past(pad_in[0])
            && !trickle_supply_power_on_reset
            |=> s_r.int_sts[`GPCM_EV_EDGE3];
    endproperty
    a_edge3: assert property (p_edge3)
        else $error("edge interrupt three not latched");

    property p_lock_forced_in;
        lock_sel |-> pad_oe_n[0] && pin_sense[0] == pad_in[0];
    endproperty
    a_lock_forced_in: assert property (p_lock_forced_in)
        else $error("lock pin not plain input");

    property p_lock_sticky;
        lock_sel && !main_supply_power_on_reset && !hard_reset
            && !trickle_supply_power_on_reset |=> lock_sel;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock field left without reset");

    property p_lock_reset;
        main_supply_power_on_reset || hard_reset
            || trickle_supply_power_on_reset |=> func43 == 2'h0;
    endproperty
    a_lock_reset: assert property (p_lock_reset)
        else $error("lock field not cleared by reset");

    property p_dis_ro;
        wr_lo && s_r.aw_addr == `GPCM_ADDR_DEV_DIS && lock_ro
            |=> $stable(s_r.dev_dis);
    endproperty
    a_dis_ro: assert property (p_dis_ro)
        else $error("locked disable register changed");

    property p_dis_rw;
        wr_lo && s_r.aw_addr == `GPCM_ADDR_DEV_DIS && !lock_ro
            |=> device_disable == $past(s_r.w_data[7:0]);
    endproperty
    a_dis_rw: assert property (p_dis_rw)
        else $error("disable register write lost");

    property p_irq4_route;
        func51 == `GPCM_FUNC_ALT2 |-> irq4 == pin_sense[2];
    endproperty
    a_irq4_route: assert property (p_irq4_route)
        else $error("irq4 not following pin");

    property p_irq3_route;
        func50 == `GPCM_FUNC_ALT2 |-> irq3 == pin_sense[1];
    endproperty
    a_irq3_route: assert property (p_irq3_route)
        else $error("irq3 not following pin");

    property p_gpio_plain;
        func50 == `GPCM_FUNC_GPIO |-> !irq3 && serial2_ring_indicator;
    endproperty
    a_gpio_plain: assert property (p_gpio_plain)
        else $error("gpio pin still routed");

    // Push-pull only: open drain hides the high level behind the pull-up
    property p_floppy_drive;
        func43 == `GPCM_FUNC_ALT2 && !pad_oe_n[0]
            && !s_r.cfg[0][`GPCM_BIT_OD] |-> pad_out[0]
            == (floppy_on_parallel_indicator ^ s_r.cfg[0][`GPCM_BIT_POL]);
    endproperty
    a_floppy_drive: assert property (p_floppy_drive)
        else $error("floppy indicator not on pin");

    property p_floppy_event;
        func43 == `GPCM_FUNC_ALT2 && pad_in[0] != $past(pad_in[0])
            |=> s_r.int_sts[`GPCM_EV_FLOPPY];
    endproperty
    a_floppy_event: assert property (p_floppy_event)
        else $error("floppy edge not latched");
endmodule // gpcm_top

// File: verilog/gpcm_regs.svh
`ifndef GPCM_REGS_SVH
`define GPCM_REGS_SVH

// Printed offsets are register indices; byte address is index times four
`define GPCM_IDX_CFG43 8'h3E
`define GPCM_IDX_CFG50 8'h3F
`define GPCM_IDX_CFG51 8'h40
`define GPCM_ADDR_CFG43 {2'h0, `GPCM_IDX_CFG43, 2'h0}
`define GPCM_ADDR_CFG50 {2'h0, `GPCM_IDX_CFG50, 2'h0}
`define GPCM_ADDR_CFG51 {2'h0, `GPCM_IDX_CFG51, 2'h0}
`define GPCM_ADDR_DATA 12'h000
`define GPCM_ADDR_INT_STS 12'h004
`define GPCM_ADDR_INT_CLR 12'h008
`define GPCM_ADDR_INT_EN 12'h00C
`define GPCM_ADDR_DEV_DIS 12'h010

`define GPCM_BIT_DIR 0
`define GPCM_BIT_POL 1
`define GPCM_FUNC_LSB 2
`define GPCM_FUNC_MSB 3
`define GPCM_BIT_OD 7
`define GPCM_DATA_IN_LSB 8

`define GPCM_FUNC_GPIO 2'h0
`define GPCM_FUNC_ALT1 2'h1
`define GPCM_FUNC_ALT2 2'h2
`define GPCM_FUNC_ALT3 2'h3

`define GPCM_CFG_RST 8'h01
`define GPCM_EV_EDGE3 0
`define GPCM_EV_FLOPPY 1

`define GPCM_RESP_OKAY 2'h0
`define GPCM_RESP_SLVERR 2'h2

`endif

// File: verilog/gpcm_pkg.sv
package gpcm_pkg;

    typedef struct packed {
        logic [2:0][7:0] cfg;
        logic [2:0] gpio_out;
        logic [7:0] dev_dis;
        logic [1:0] int_sts;
        logic [1:0] int_en;
        logic [2:0] pin_prev;
        logic aw_v;
        logic [11:0] aw_addr;
        logic w_v;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic b_v;
        logic [1:0] b_resp;
        logic r_v;
        logic [31:0] r_data;
        logic [1:0] r_resp;
    } gpcm_state_t;

endpackage

// File: verilog/gpcm_pin.sv
`timescale 1ns/1ps
`include "gpcm_regs.svh"

module gpcm_pin (
    input wire logic [7:0] cfg,
    input wire logic force_in,
    input wire logic gpio_out,
    input wire logic alt_drive,
    input wire logic alt_value,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_n,
    output logic pin_sense
);
    logic is_in;
    logic pol;
    logic drv;

    assign is_in = cfg[`GPCM_BIT_DIR] | force_in;
    assign pol = cfg[`GPCM_BIT_POL] & ~force_in;
    assign drv = (alt_drive ? alt_value : gpio_out) ^ pol;
    assign pin_sense = pad_in ^ pol;

    always_comb begin
        if (is_in) begin
            pad_out = 1'b0;
            pad_oe_n = 1'b1;
        end else if (cfg[`GPCM_BIT_OD]) begin
            // Open drain only pulls low; a high is left to the pull-up
            pad_out = 1'b0;
            pad_oe_n = drv;
        end else begin
            pad_out = drv;
            pad_oe_n = 1'b0;
        end
    end
endmodule // gpcm_pin

// File: dv/gpcm_pad_model.sv
`timescale 1ns/1ps

module gpcm_pad_model (
    input wire logic [2:0] pad_out,
    input wire logic [2:0] pad_oe_n,
    input wire logic [2:0] brd_val,
    input wire logic [2:0] brd_en,
    output logic [2:0] pad_in
);
    // Board pull-up: an undriven or released pin reads high, never a stale 0
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (!pad_oe_n[i]) begin
                pad_in[i] = pad_out[i];
            end else if (brd_en[i]) begin
                pad_in[i] = brd_val[i];
            end else begin
                pad_in[i] = 1'b1;
            end
        end
    end
endmodule // gpcm_pad_model

// File: dv/gpio_pin_config_mux_bench.sv
`timescale 1ns/1ps
`include "gpcm_regs.svh"

module gpio_pin_config_mux_bench;
    logic clk_sys = 1'b0, srst = 1'b1, tsp = 1'b0, msp = 1'b0, hrst = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [1:0] r;
    logic [2:0] pad_in, pad_out, pad_oe_n;
    logic [2:0] brd_val = 3'h0, brd_en = 3'h0;
    logic fpi = 1'b0;
    logic irq3, irq4, ri, cd, lockf, irq;
    logic [7:0] dev_dis;
    logic [11:0] cfga [3] = '{`GPCM_ADDR_CFG43, `GPCM_ADDR_CFG50,
        `GPCM_ADDR_CFG51};
    int n_fail = 0, tests_run = 0, cyc = 0;
    int p, v;

    always #10 clk_sys = ~clk_sys;

    gpcm_top dut (.clk_sys(clk_sys), .srst(srst),
        .trickle_supply_power_on_reset(tsp),
        .main_supply_power_on_reset(msp), .hard_reset(hrst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .floppy_on_parallel_indicator(fpi),
        .irq3(irq3), .irq4(irq4), .serial2_ring_indicator(ri),
        .serial2_carrier_detect(cd), .device_disable(dev_dis),
        .disable_register_lock_function(lockf), .irq(irq));

    gpcm_pad_model board (.pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .brd_val(brd_val), .brd_en(brd_en), .pad_in(pad_in));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        chk({31'h0, got}, {31'h0, exp}, m);
    endtask

    // Each channel released on the edge that takes it; no cycle count assumed
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge clk_sys);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                aw_d = 1'b1;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                w_d = 1'b1;
            end
        end
        do @(posedge clk_sys); while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, `GPCM_RESP_OKAY}, "write response");
        // Let an edge pass so a following write never re-raises bready
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk_sys);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
        input string m);
        rd(a);
        chk({30'h0, r}, {30'h0, `GPCM_RESP_OKAY}, "read response");
        chk(d, e, m);
    endtask

    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic pulse(input int k);
        {tsp, msp, hrst} <= 3'h1 << k;
        @(posedge clk_sys);
        {tsp, msp, hrst} <= 3'h0;
        @(posedge clk_sys);
    endtask

    // Whole run needs a few hundred cycles; the ceiling leaves ample slack
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 3; i++) begin
            rd_chk(cfga[i], 32'h01, "cfg reset");
        end
        wr(cfga[1], 32'h00);
        wr(`GPCM_ADDR_DATA, 32'h2);
        settle();
        chk_bit(pad_oe_n[1], 1'b0, "output enable");
        chk_bit(pad_out[1], 1'b1, "gpio drive");
        wr(cfga[1], 32'h02);
        chk_bit(pad_out[1], 1'b0, "inverted drive");
        wr(cfga[1], 32'h80);
        chk_bit(pad_oe_n[1], 1'b1, "open drain release");
        wr(`GPCM_ADDR_DATA, 32'h0);
        chk_bit(pad_oe_n[1] | pad_out[1], 1'b0, "open drain low");
        brd_en[1] <= 1'b1;
        brd_val[1] <= 1'b1;
        wr(cfga[1], 32'h03);
        settle();
        chk_bit(pad_oe_n[1], 1'b1, "input mode");
        rd(`GPCM_ADDR_DATA);
        chk_bit(d[9], 1'b0, "inverted sense");
        wr(cfga[1], 32'h71);
        settle();
        rd(`GPCM_ADDR_DATA);
        chk_bit(d[9] & pad_oe_n[1], 1'b1, "reserved bits inert");
        // Port5 code 11 is left alone: it routes as plain GPIO
        for (p = 1; p < 3; p++) begin
            brd_en[p] <= 1'b1;
            for (v = 0; v < 2; v++) begin
                brd_val[p] <= v[0];
                wr(cfga[p], 32'h09);
                settle();
                chk_bit(p == 1 ? irq3 : irq4, v[0],
                    "irq route");
                wr(cfga[p], 32'h05);
                settle();
                chk_bit(p == 1 ? ri : cd, v[0],
                    "modem route");
                wr(cfga[p], 32'h01);
                chk_bit((p == 1 ? irq3 : irq4) | ~(p == 1 ? ri : cd), 1'b0,
                    "gpio route");
            end
        end
        brd_en[0] <= 1'b1;
        brd_val[0] <= 1'b0;
        wr(cfga[0], 32'h0D);
        wr(`GPCM_ADDR_INT_EN, 32'h1);
        wr(`GPCM_ADDR_INT_CLR, 32'h3);
        chk_bit(irq, 1'b0, "irq idle");
        brd_val[0] <= 1'b1;
        settle();
        rd_chk(`GPCM_ADDR_INT_STS, 32'h1, "rising edge event");
        chk_bit(irq, 1'b1, "irq raised");
        wr(`GPCM_ADDR_INT_EN, 32'h0);
        chk_bit(irq, 1'b0, "irq masked");
        wr(`GPCM_ADDR_INT_CLR, 32'h1);
        rd_chk(`GPCM_ADDR_INT_STS, 32'h0, "event cleared");
        brd_val[0] <= 1'b0;
        settle();
        rd_chk(`GPCM_ADDR_INT_STS, 32'h1, "falling edge event");
        wr(`GPCM_ADDR_INT_CLR, 32'h1);
        brd_en[0] <= 1'b0;
        fpi <= 1'b1;
        wr(cfga[0], 32'h08);
        chk_bit(pad_out[0], 1'b1, "floppy indicator");
        // Releasing the pin under code 11 raised a real edge; drop it
        wr(`GPCM_ADDR_INT_CLR, 32'h3);
        wr(cfga[0], 32'h0A);
        chk_bit(pad_out[0], 1'b0, "floppy inverted");
        settle();
        rd_chk(`GPCM_ADDR_INT_STS, 32'h2, "floppy edge event");
        wr(`GPCM_ADDR_INT_EN, 32'h2);
        chk_bit(irq, 1'b1, "floppy irq");
        wr(`GPCM_ADDR_INT_CLR, 32'h3);
        wr(cfga[0], 32'h01);
        brd_en[0] <= 1'b1;
        brd_val[0] <= 1'b1;
        wr(`GPCM_ADDR_DEV_DIS, 32'hA5);
        rd_chk(`GPCM_ADDR_DEV_DIS, 32'hA5, "unlocked write");
        wr(cfga[0], 32'h06);
        settle();
        chk_bit(pad_oe_n[0] & lockf, 1'b1, "lock forces input");
        rd(`GPCM_ADDR_DATA);
        chk_bit(d[8], 1'b1, "lock sense not inverted");
        wr(cfga[0], 32'h01);
        rd(cfga[0]);
        chk({30'h0, d[3:2]}, 32'h1, "field held");
        wr(`GPCM_ADDR_DEV_DIS, 32'h3C);
        rd_chk(`GPCM_ADDR_DEV_DIS, 32'hA5, "locked read-only");
        brd_val[0] <= 1'b0;
        settle();
        wr(`GPCM_ADDR_DEV_DIS, 32'h3C);
        rd_chk(`GPCM_ADDR_DEV_DIS, 32'h3C, "locked writable");
        chk({24'h0, dev_dis}, 32'h3C, "disable output");
        for (int k = 0; k < 3; k++) begin
            wr(cfga[0], 32'h05);
            pulse(k);
            rd(cfga[0]);
            chk({30'h0, d[3:2]}, 32'h0, "reset unlocks");
        end
        rd(12'h200);
        chk({30'h0, r}, {30'h0, `GPCM_RESP_SLVERR},
            "unmapped resp");
        chk(d, 32'h0, "unmapped data");
        end_sim();
    end
endmodule // gpio_pin_config_mux_bench
